// File: logic/ddr2c_core.v
// Purpose: command decode and bank state of a ddr2 sdram device
// Assumes: command pins are sampled through two flops; settings are static
// Notes:   latencies come from setting inputs, no mode register decode here
// Overview of operation
// RULE1 - controller waits termination turn-off delay before changing termination setting.
// RULE2 - controller holds termination low through whole mode-update window.
// RULE3 - activate decodes cs, ras low; bank and row latched; needed before access.
// RULE4 - read or write accepted clock after activate; additive latency 0 to 6.
// RULE5 - controller precharges before re-activate and spaces activates properly.
// RULE6 - controller issues at most four activates per rolling window.
// RULE7 - controller allows single precharge time plus one clock after precharge all.
// RULE8 - read decode; bank, column taken; a10 low leaves row open.
// RULE9 - write decode; bank, column taken; a10 picks auto-precharge.
// RULE10 - read with a10 high precharges row after burst ends.
// RULE11 - read auto-precharge starts additive latency plus half burst after command.
// RULE12 - write auto-precharge starts after burst plus write recovery.
// RULE13 - precharge all with a10 high idles every bank, bank bits ignored.
// RULE14 - controller turns termination off before self refresh entry.
// RULE15 - self refresh uses internal timer, dll off, stays while cke low.
// RULE16 - controller may stop clock after entry, restart before exit.
// RULE17 - controller sends only nop or deselect until exit delay passes.
// RULE18 - controller keeps cke high for whole exit period.
// RULE19 - controller issues one refresh after exit before re-entry.
// RULE20 - auto refresh with cke high uses internal address, idles banks.
// RULE21 - controller waits refresh cycle time and averages one per interval.
// RULE22 - controller posts at most eight refreshes, gap under nine intervals.
// RULE23 - cs low with ras, cas, we high is a no-operation.
// RULE24 - cs high disables decoder; treated as no-operation.
// RULE25 - read latency is additive plus cas latency; write one less.
// RULE26 - controller tracks bank state and checks timing per bank.
`timescale 1ns/1ns
`include "ddr2c_map.vh"
module ddr2c_core #(
  parameter SR_TICK_CYC = `DDR2C_SR_TICK_CYC
) (
  // clock and reset
  input  wire                        ref_clk,
  input  wire                        srst,
  // command pins, active low strobes
  input  wire                        cs_n,
  input  wire                        ras_n,
  input  wire                        cas_n,
  input  wire                        we_n,
  input  wire                        cke,
  input  wire [`DDR2C_BANK_W-1:0]    ba,
  input  wire [`DDR2C_ADDR_W-1:0]    addr,
  // latency settings
  input  wire [2:0]                  al,
  input  wire [2:0]                  cl,
  input  wire                        bl8,
  input  wire [2:0]                  wr_rec,
  // bank and mode state
  output reg  [`DDR2C_BANKS-1:0]     bank_open,
  output reg                         self_refresh,
  output reg                         dll_enabled,
  output reg                         refresh_pulse,
  output reg  [`DDR2C_ROW_W-1:0]     refresh_row,
  // column access
  output reg                         col_valid,
  output reg                         col_write,
  output reg  [`DDR2C_BANK_W-1:0]    col_bank,
  output reg  [`DDR2C_COL_W-1:0]     col_addr,
  output reg  [`DDR2C_ROW_W-1:0]     col_row,
  output reg  [3:0]                  col_latency,
  output reg                         col_error
);
  wire s_cs_n;
  wire s_ras_n;
  wire s_cas_n;
  wire s_we_n;
  wire s_cke;
  reg  [`DDR2C_BANK_W-1:0] ba_q1;
  reg  [`DDR2C_BANK_W-1:0] ba_q2;
  reg  [`DDR2C_ADDR_W-1:0] addr_q1;
  reg  [`DDR2C_ADDR_W-1:0] addr_q2;
  reg                      cke_prev;
  // pin synchronisers
  ddr2c_sync u_cs (.ref_clk(ref_clk), .srst(srst), .din(cs_n),  .dout(s_cs_n));
  ddr2c_sync u_ras (.ref_clk(ref_clk), .srst(srst), .din(ras_n), .dout(s_ras_n));
  ddr2c_sync u_cas (.ref_clk(ref_clk), .srst(srst), .din(cas_n), .dout(s_cas_n));
  ddr2c_sync u_we (.ref_clk(ref_clk), .srst(srst), .din(we_n),  .dout(s_we_n));
  ddr2c_sync u_cke (.ref_clk(ref_clk), .srst(srst), .din(cke),   .dout(s_cke));
  // buses kept in step with the strobe synchronisers
  always @(posedge ref_clk) begin
    if (srst) begin
      ba_q1    <= {`DDR2C_BANK_W{1'b0}};
      ba_q2    <= {`DDR2C_BANK_W{1'b0}};
      addr_q1  <= {`DDR2C_ADDR_W{1'b0}};
      addr_q2  <= {`DDR2C_ADDR_W{1'b0}};
      cke_prev <= 1'b1;
    end else begin
      ba_q1    <= ba;
      ba_q2    <= ba_q1;
      addr_q1  <= addr;
      addr_q2  <= addr_q1;
      cke_prev <= s_cke;
    end
  end

  // RULE23 RULE24 nop and deselect ignored
  wire [2:0] cmd = s_cs_n ? `DDR2C_CMD_NOP : {s_ras_n, s_cas_n, s_we_n};
  wire       live = !self_refresh && s_cke;
  wire       ap   = addr_q2[`DDR2C_AP_BIT];
  // RULE3 activate decode
  wire       is_act = live && cmd == `DDR2C_CMD_ACT;
  // RULE8 read decode
  wire       is_rd  = live && cmd == `DDR2C_CMD_RD;
  // RULE9 write decode
  wire       is_wr  = live && cmd == `DDR2C_CMD_WR;
  wire       is_pre = live && cmd == `DDR2C_CMD_PRE;
  // RULE20 refresh with cke high
  wire       is_ref = live && cke_prev && cmd == `DDR2C_CMD_REF;
  // RULE15 self refresh entry on cke low
  wire       is_sre = !self_refresh && cke_prev && !s_cke && cmd == `DDR2C_CMD_REF;

  // RULE25 read latency al plus cl
  wire [3:0] rd_lat = {1'b0, al} + {1'b0, cl};
  wire [3:0] wr_lat = rd_lat - 4'h1;
  wire [3:0] half_bl = bl8 ? 4'h4 : 4'h2;
  // RULE11 al plus half burst
  wire [`DDR2C_CNT_W-1:0] rd_ap_dly = {5'h00, al} + {4'h0, half_bl};
  // RULE12 burst then write recovery
  wire [`DDR2C_CNT_W-1:0] wr_ap_dly = {4'h0, wr_lat} + {4'h0, half_bl} + {5'h00, wr_rec};
  wire [`DDR2C_CNT_W-1:0] ap_dly = is_wr ? wr_ap_dly : rd_ap_dly;

  wire [`DDR2C_BANKS-1:0]              open_w;
  wire [`DDR2C_ROW_W*`DDR2C_BANKS-1:0] row_w;
  // RULE13 precharge all ignores bank bits
  wire pre_all = is_pre && ap;
  // RULE20 refresh leaves banks idle
  wire idle_all = pre_all || is_ref || is_sre;
  // one-hot bank select from the delayed bank bits
  wire [`DDR2C_BANKS-1:0] bank_hit = {{(`DDR2C_BANKS-1){1'b0}}, 1'b1} << ba_q2;
  wire [`DDR2C_BANKS-1:0] act_sel  = {`DDR2C_BANKS{is_act}} & bank_hit;
  wire [`DDR2C_BANKS-1:0] pre_sel  = {`DDR2C_BANKS{idle_all}} | ({`DDR2C_BANKS{is_pre}} & bank_hit);
  // RULE10 auto-precharge armed by a10
  wire [`DDR2C_BANKS-1:0] ap_sel   = {`DDR2C_BANKS{(is_rd || is_wr) && ap}} & bank_hit;

  // eight bank trackers; each keeps its own auto-precharge count
  ddr2c_bank u_bank0 (
    .ref_clk   (ref_clk),
    .srst      (srst),
    .act       (act_sel[0]),
    .act_row   (addr_q2),
    .pre       (pre_sel[0]),
    .ap_arm    (ap_sel[0]),
    .ap_delay  (ap_dly),
    .open      (open_w[0]),
    .row       (row_w[`DDR2C_ROW_W*0 +: `DDR2C_ROW_W]),
    .ap_pending(),
    .ap_fire   ()
  );

  ddr2c_bank u_bank1 (
    .ref_clk   (ref_clk),
    .srst      (srst),
    .act       (act_sel[1]),
    .act_row   (addr_q2),
    .pre       (pre_sel[1]),
    .ap_arm    (ap_sel[1]),
    .ap_delay  (ap_dly),
    .open      (open_w[1]),
    .row       (row_w[`DDR2C_ROW_W*1 +: `DDR2C_ROW_W]),
    .ap_pending(),
    .ap_fire   ()
  );

  ddr2c_bank u_bank2 (
    .ref_clk   (ref_clk),
    .srst      (srst),
    .act       (act_sel[2]),
    .act_row   (addr_q2),
    .pre       (pre_sel[2]),
    .ap_arm    (ap_sel[2]),
    .ap_delay  (ap_dly),
    .open      (open_w[2]),
    .row       (row_w[`DDR2C_ROW_W*2 +: `DDR2C_ROW_W]),
    .ap_pending(),
    .ap_fire   ()
  );

  ddr2c_bank u_bank3 (
    .ref_clk   (ref_clk),
    .srst      (srst),
    .act       (act_sel[3]),
    .act_row   (addr_q2),
    .pre       (pre_sel[3]),
    .ap_arm    (ap_sel[3]),
    .ap_delay  (ap_dly),
    .open      (open_w[3]),
    .row       (row_w[`DDR2C_ROW_W*3 +: `DDR2C_ROW_W]),
    .ap_pending(),
    .ap_fire   ()
  );

  ddr2c_bank u_bank4 (
    .ref_clk   (ref_clk),
    .srst      (srst),
    .act       (act_sel[4]),
    .act_row   (addr_q2),
    .pre       (pre_sel[4]),
    .ap_arm    (ap_sel[4]),
    .ap_delay  (ap_dly),
    .open      (open_w[4]),
    .row       (row_w[`DDR2C_ROW_W*4 +: `DDR2C_ROW_W]),
    .ap_pending(),
    .ap_fire   ()
  );

  ddr2c_bank u_bank5 (
    .ref_clk   (ref_clk),
    .srst      (srst),
    .act       (act_sel[5]),
    .act_row   (addr_q2),
    .pre       (pre_sel[5]),
    .ap_arm    (ap_sel[5]),
    .ap_delay  (ap_dly),
    .open      (open_w[5]),
    .row       (row_w[`DDR2C_ROW_W*5 +: `DDR2C_ROW_W]),
    .ap_pending(),
    .ap_fire   ()
  );

  ddr2c_bank u_bank6 (
    .ref_clk   (ref_clk),
    .srst      (srst),
    .act       (act_sel[6]),
    .act_row   (addr_q2),
    .pre       (pre_sel[6]),
    .ap_arm    (ap_sel[6]),
    .ap_delay  (ap_dly),
    .open      (open_w[6]),
    .row       (row_w[`DDR2C_ROW_W*6 +: `DDR2C_ROW_W]),
    .ap_pending(),
    .ap_fire   ()
  );

  ddr2c_bank u_bank7 (
    .ref_clk   (ref_clk),
    .srst      (srst),
    .act       (act_sel[7]),
    .act_row   (addr_q2),
    .pre       (pre_sel[7]),
    .ap_arm    (ap_sel[7]),
    .ap_delay  (ap_dly),
    .open      (open_w[7]),
    .row       (row_w[`DDR2C_ROW_W*7 +: `DDR2C_ROW_W]),
    .ap_pending(),
    .ap_fire   ()
  );

  wire sel_open = open_w[ba_q2];
  reg [31:0] sr_timer;
  always @(posedge ref_clk) begin
    if (srst) begin
      bank_open     <= {`DDR2C_BANKS{1'b0}};
      self_refresh  <= 1'b0;
      dll_enabled   <= 1'b1;
      refresh_pulse <= 1'b0;
      refresh_row   <= `DDR2C_ROW_RST;
      sr_timer      <= 32'h0000_0000;
      col_valid     <= 1'b0;
      col_write     <= 1'b0;
      col_bank      <= {`DDR2C_BANK_W{1'b0}};
      col_addr      <= {`DDR2C_COL_W{1'b0}};
      col_row       <= `DDR2C_ROW_RST;
      col_latency   <= 4'h0;
      col_error     <= 1'b0;
    end else begin
      bank_open     <= open_w;
      refresh_pulse <= 1'b0;
      col_valid     <= 1'b0;
      col_error     <= 1'b0;
      // RULE15 internal timer, dll off in self refresh
      if (is_sre) begin
        self_refresh <= 1'b1;
        dll_enabled  <= 1'b0;
        sr_timer     <= 32'h0000_0000;
      end else if (self_refresh) begin
        if (s_cke) begin
          self_refresh <= 1'b0;
          dll_enabled  <= 1'b1;
        end else if (sr_timer >= SR_TICK_CYC - 1) begin
          sr_timer      <= 32'h0000_0000;
          refresh_pulse <= 1'b1;
          refresh_row   <= refresh_row + 15'h0001;
        end else begin
          sr_timer <= sr_timer + 32'h0000_0001;
        end
      end
      // RULE20 internal refresh address
      if (is_ref) begin
        refresh_pulse <= 1'b1;
        refresh_row   <= refresh_row + 15'h0001;
      end
      // RULE4 column access after activate; al above six flags col_error
      if (is_rd || is_wr) begin
        col_valid   <= sel_open;
        col_error   <= !sel_open || al > `DDR2C_AL_MAX;
        col_write   <= is_wr;
        col_bank    <= ba_q2;
        col_addr    <= addr_q2[`DDR2C_COL_W-1:0];
        col_row     <= row_w[ba_q2*`DDR2C_ROW_W +: `DDR2C_ROW_W];
        col_latency <= is_wr ? wr_lat : rd_lat;
      end
    end
  end
endmodule

// File: include/ddr2c_map.vh
// Purpose: constants for the ddr2 command function block
// Assumes: 8 banks, 15-bit row, 10-bit column, 50 MHz command clock
// Notes:   latencies and recovery are plain input settings
`ifndef DDR2C_MAP_VH
`define DDR2C_MAP_VH
`define DDR2C_BANKS        8
`define DDR2C_BANK_W       3
`define DDR2C_ADDR_W       15
`define DDR2C_ROW_W        15
`define DDR2C_COL_W        10
`define DDR2C_AP_BIT       10
`define DDR2C_AL_MAX       3'h6
`define DDR2C_CNT_W        8
`define DDR2C_CMD_NOP      3'b111
`define DDR2C_CMD_ACT      3'b011
`define DDR2C_CMD_RD       3'b101
`define DDR2C_CMD_WR       3'b100
`define DDR2C_CMD_PRE      3'b010
`define DDR2C_CMD_REF      3'b001
`define DDR2C_SR_TICK_NS   7800
`define DDR2C_CLK_NS       20
`define DDR2C_SR_TICK_CYC  ((`DDR2C_SR_TICK_NS + `DDR2C_CLK_NS - 1) / `DDR2C_CLK_NS)
`define DDR2C_ROW_RST      15'h0000
`endif

// File: logic/ddr2c_sync.v
// Purpose: two-flop synchroniser for one pin
// Assumes: single clock domain ref_clk
// Notes:   first stage is read by the second stage only
`timescale 1ns/1ns
module ddr2c_sync (
  // clock and reset
  input  wire ref_clk,
  input  wire srst,
  // pin in, synchronised out
  input  wire din,
  output reg  dout
);
  reg meta;
  always @(posedge ref_clk) begin
    if (srst) begin
      meta <= 1'b1;
      dout <= 1'b1;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule

// File: logic/ddr2c_bank.v
// Purpose: state of one bank with pending auto-precharge
// Assumes: decoded commands arrive as one-cycle pulses
// Notes:   a new activate while open is ignored; controller must precharge first
`timescale 1ns/1ns
`include "ddr2c_map.vh"
module ddr2c_bank (
  // clock and reset
  input  wire                        ref_clk,
  input  wire                        srst,
  // commands to this bank
  input  wire                        act,
  input  wire [`DDR2C_ROW_W-1:0]     act_row,
  input  wire                        pre,
  input  wire                        ap_arm,
  input  wire [`DDR2C_CNT_W-1:0]     ap_delay,
  // state
  output reg                         open,
  output reg  [`DDR2C_ROW_W-1:0]     row,
  output reg                         ap_pending,
  output reg                         ap_fire
);
  reg [`DDR2C_CNT_W-1:0] ap_cnt;
  always @(posedge ref_clk) begin
    if (srst) begin
      open       <= 1'b0;
      row        <= `DDR2C_ROW_RST;
      ap_pending <= 1'b0;
      ap_cnt     <= {`DDR2C_CNT_W{1'b0}};
      ap_fire    <= 1'b0;
    end else begin
      ap_fire <= 1'b0;
      if (ap_arm && open) begin
        ap_pending <= 1'b1;
        ap_cnt     <= ap_delay;
      end else if (ap_pending) begin
        if (ap_cnt <= 8'h01) begin
          ap_pending <= 1'b0;
          ap_fire    <= 1'b1;
        end else begin
          ap_cnt <= ap_cnt - 8'h01;
        end
      end
      if (pre || (ap_pending && ap_cnt <= 8'h01 && !(ap_arm && open))) begin
        open <= 1'b0;
        if (pre)
          ap_pending <= 1'b0;
      end else if (act && !open) begin
        open <= 1'b1;
        row  <= act_row;
      end
    end
  end
endmodule

// File: verification/ddr2c_props.sv
// Purpose: pin-level checks on ddr2c_core
// Assumes: pins decode two edges after sampling; settings static
// Notes: reads and writes are checked only to banks open long enough
`timescale 1ns/1ns
`include "ddr2c_map.vh"
module ddr2c_props #(
  parameter SR_TICK_CYC = 8
) (
  // clock and reset
  input wire                     ref_clk,
  input wire                     srst,
  // pins and settings
  input wire                     cs_n,
  input wire                     ras_n,
  input wire                     cas_n,
  input wire                     we_n,
  input wire                     cke,
  input wire [`DDR2C_BANK_W-1:0] ba,
  input wire [`DDR2C_ADDR_W-1:0] addr,
  input wire [2:0]               al,
  input wire [2:0]               cl,
  // results
  input wire [`DDR2C_BANKS-1:0]  bank_open,
  input wire                     self_refresh,
  input wire                     dll_enabled,
  input wire                     refresh_pulse,
  input wire                     col_valid,
  input wire                     col_write,
  input wire [`DDR2C_BANK_W-1:0] col_bank,
  input wire [`DDR2C_COL_W-1:0]  col_addr,
  input wire [3:0]               col_latency
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  wire [2:0] c   = {ras_n, cas_n, we_n};
  wire       go  = !cs_n && cke && !self_refresh;
  wire       rw  = go && (c == `DDR2C_CMD_RD || c == `DDR2C_CMD_WR);
  wire [9:0] col = addr[9:0];
  reg  [9:0] gap;
  // gap since last internal refresh; cleared outside self refresh
  always @(posedge ref_clk) gap <= (srst || refresh_pulse || !self_refresh) ? 10'h000 : gap + 10'h001;
  sequence s_col; ##3 col_valid; endsequence
  sequence s_ref; ##3 refresh_pulse ##1 bank_open == 8'h00; endsequence
  a_col_decode: assert property (rw && bank_open[ba] |-> s_col) else $error("access not reported");
  a_col_fields: assert property (col_valid |-> col_bank == $past(ba, 3) && col_addr == $past(col, 3)
    && col_write == !$past(we_n, 3)) else $error("access fields wrong");
  a_col_lat: assert property (col_valid |-> col_latency == {1'b0, al} + {1'b0, cl} - {3'h0, col_write})
    else $error("latency wrong");
  a_act_opens: assert property (go && c == `DDR2C_CMD_ACT |-> ##4 bank_open[$past(ba, 4)])
    else $error("bank not opened");
  a_pall_idle: assert property (go && c == `DDR2C_CMD_PRE && addr[10] |-> ##4 bank_open == 8'h00)
    else $error("banks left open");
  a_ref_idle: assert property (go && c == `DDR2C_CMD_REF && $past(cke) |-> s_ref)
    else $error("refresh missing");
  a_nop_quiet: assert property (cs_n || c == `DDR2C_CMD_NOP |-> ##3 !col_valid)
    else $error("idle gave access");
  a_sr_dll: assert property (self_refresh && $past(self_refresh) |-> !dll_enabled)
    else $error("dll on in self refresh");
  a_sr_tick: assert property (self_refresh |-> gap <= SR_TICK_CYC + 1)
    else $error("self refresh tick late");
endmodule
bind ddr2c_core ddr2c_props #(.SR_TICK_CYC(SR_TICK_CYC)) i_ddr2c_props (.ref_clk(ref_clk), .srst(srst),
  .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .cke(cke), .ba(ba), .addr(addr), .al(al), .cl(cl),
  .bank_open(bank_open), .self_refresh(self_refresh), .dll_enabled(dll_enabled), .refresh_pulse(refresh_pulse),
  .col_valid(col_valid), .col_write(col_write), .col_bank(col_bank), .col_addr(col_addr),
  .col_latency(col_latency));

// File: verification/ddr2c_ctrl.sv
// Purpose: controller model driving the command pins
// Assumes: one command then a nop, at falling edges
// Notes: released address lines are inverted so stale values never match
`timescale 1ns/1ns
`include "ddr2c_map.vh"
module ddr2c_ctrl (
  // clock
  input wire                    ref_clk,
  // command pins
  output reg                    cs_n,
  output reg                    ras_n,
  output reg                    cas_n,
  output reg                    we_n,
  output reg                    cke,
  output reg [`DDR2C_BANK_W-1:0] ba,
  output reg [`DDR2C_ADDR_W-1:0] addr
);
  // termination never updated, odt stays off
  initial {cs_n, ras_n, cas_n, we_n, cke, ba, addr} = {5'h1f, 3'h0, 15'h0000};
  task issue(input [2:0] c, input [2:0] b, input [14:0] a, input k, input integer w);
    begin
      @(negedge ref_clk);
      {cs_n, ras_n, cas_n, we_n, cke, ba, addr} <= {1'b0, c, k, b, a};
      @(negedge ref_clk);
      {ras_n, cas_n, we_n} <= `DDR2C_CMD_NOP;
      {ba, addr} <= ~{b, a};
      repeat (w) @(negedge ref_clk);
    end
  endtask
endmodule

// File: verification/ddr2c_core_tb.sv
// Purpose: self-checking bench for ddr2c_core
// Assumes: settings drawn once before reset
// Notes: column results queued by the model in issue order
`timescale 1ns/1ns
`include "ddr2c_map.vh"
module ddr2c_core_tb;
  reg         ref_clk, srst, bl8;
  reg  [2:0]  al, cl, wr_rec, b;
  wire        cs_n, ras_n, cas_n, we_n, cke, self_refresh, dll_enabled, refresh_pulse;
  wire        col_valid, col_write, col_error;
  wire [2:0]  ba, col_bank;
  wire [14:0] addr, refresh_row, col_row;
  wire [7:0]  bank_open;
  wire [9:0]  col_addr;
  wire [3:0]  col_latency;
  reg  [14:0] rows [0:7];
  reg  [7:0]  mopen;
  reg  [34:0] e, q [$];
  reg  [9:0]  c;
  integer     errors, checks, i, d;
  localparam integer FAW_GAP = 10;
  ddr2c_ctrl i_ddr2c_ctrl (.ref_clk(ref_clk), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
    .cke(cke), .ba(ba), .addr(addr));
  ddr2c_core #(.SR_TICK_CYC(8)) i_ddr2c_core (.ref_clk(ref_clk), .srst(srst), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .cke(cke), .ba(ba), .addr(addr), .al(al), .cl(cl), .bl8(bl8),
    .wr_rec(wr_rec), .bank_open(bank_open), .self_refresh(self_refresh), .dll_enabled(dll_enabled),
    .refresh_pulse(refresh_pulse), .refresh_row(refresh_row), .col_valid(col_valid), .col_write(col_write),
    .col_bank(col_bank), .col_addr(col_addr), .col_row(col_row), .col_latency(col_latency),
    .col_error(col_error));
  task cmp_col(input [34:0] x, input [34:0] g);
    begin
      checks = checks + 1;
      if (g !== x) begin
        errors = errors + 1;
        $display("wrong value at %0t: expected %h, got %h", $time, x, g);
      end
    end
  endtask
  task cmp_st(input [15:0] x, input [15:0] g);
    cmp_col({19'h0, x}, {19'h0, g});
  endtask
  task give_verdict;
    begin
      if (errors == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  // model of one column access, error when the bank is idle
  task acc(input w, input [2:0] k, input ap);
    begin
      c = 10'($urandom);
      q.push_back(mopen[k] ? {2'b01, w, k, c, rows[k], {1'b0, al} + {1'b0, cl} - {3'h0, w}} : 35'h4_0000_0000);
      i_ddr2c_ctrl.issue(w ? `DDR2C_CMD_WR : `DDR2C_CMD_RD, k, {4'h0, ap, c}, 1'b1, 0);
    end
  endtask
  always @(negedge ref_clk) if (col_valid === 1'b1 || col_error === 1'b1) begin
    e = q.size() ? q.pop_front() : 35'h0;
    if (e[34]) cmp_st({14'h0, col_error, col_valid}, 16'h0002);
    else cmp_col(e, {col_error, col_valid, col_write, col_bank, col_addr, col_row, col_latency});
  end
  initial begin
    ref_clk = 0;
    forever #10 ref_clk = ~ref_clk;
  end
  initial begin
    #200000;
    errors = errors + 1;
    give_verdict;
  end
  initial begin
    {srst, errors, checks, mopen} = {1'b1, 72'h0};
    void'($urandom(99));
    al = 3'($urandom_range(6));
    cl = 3'($urandom_range(5, 3));
    bl8 = 1'($urandom);
    wr_rec = 3'($urandom_range(6, 2));
    repeat (12) @(negedge ref_clk);
    srst = 0;
    repeat (2) i_ddr2c_ctrl.issue(`DDR2C_CMD_REF, 3'h0, 15'h0000, 1'b1, 20);
    cmp_st({1'b0, refresh_row}, 16'h0002);
    for (i = 0; i < 8; i = i + 1) begin
      rows[i] = 15'($urandom);
      mopen[i] = 1'b1;
      i_ddr2c_ctrl.issue(`DDR2C_CMD_ACT, i[2:0], rows[i], 1'b1, (i % 4 == 3) ? FAW_GAP : 0);
    end
    repeat (4) @(negedge ref_clk);
    cmp_st({8'h00, bank_open}, 16'h00ff);
    repeat (12) acc(1'($urandom), 3'($urandom), 1'b0);
    cmp_st({8'h00, bank_open}, 16'h00ff);
    // single precharge, then all, with slack
    i_ddr2c_ctrl.issue(`DDR2C_CMD_PRE, 3'h5, 15'h0000, 1'b1, 4);
    mopen[5] = 1'b0;
    cmp_st({8'h00, bank_open}, {8'h00, mopen});
    i_ddr2c_ctrl.issue(`DDR2C_CMD_PRE, 3'($urandom), 15'h0400, 1'b1, 4);
    mopen = 8'h00;
    cmp_st({8'h00, bank_open}, 16'h0000);
    acc(1'b0, 3'h3, 1'b0);
    for (i = 0; i < 2; i = i + 1) begin
      b = 3'($urandom);
      mopen[b] = 1'b1;
      i_ddr2c_ctrl.issue(`DDR2C_CMD_ACT, b, rows[b], 1'b1, 6);
      acc(i[0], b, 1'b1);
      d = al + (bl8 ? 4 : 2) + (i ? cl - 1 + wr_rec : 0);
      repeat (d + 2) @(negedge ref_clk);
      cmp_st({15'h0000, bank_open[b]}, 16'h0001);
      @(negedge ref_clk);
      cmp_st({15'h0000, bank_open[b]}, 16'h0000);
      mopen[b] = 1'b0;
    end
    i_ddr2c_ctrl.issue(`DDR2C_CMD_REF, 3'h0, 15'h0000, 1'b0, 20);
    cmp_st({14'h0000, self_refresh, dll_enabled}, 16'h0002);
    i_ddr2c_ctrl.issue(`DDR2C_CMD_RD, 3'h0, 15'h0000, 1'b0, 20);
    // exit with cke high and nops
    i_ddr2c_ctrl.issue(`DDR2C_CMD_NOP, 3'h0, 15'h0000, 1'b1, 10);
    cmp_st({14'h0000, self_refresh, dll_enabled}, 16'h0001);
    i_ddr2c_ctrl.issue(`DDR2C_CMD_REF, 3'h0, 15'h0000, 1'b1, 20);
    cmp_st(16'(q.size()), 16'h0000);
    give_verdict;
  end
endmodule
